// ===== irq_priority_regs.vh
`ifndef IRQ_PRIORITY_REGS_VH
`define IRQ_PRIORITY_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PRIO_A 12'h000
`define OFS_PRIO_B 12'h004
`define OFS_PRIO_C 12'h008
`define OFS_PRIO_D 12'h00c
`define OFS_PRIO_E 12'h010
`define OFS_EVENT_CODE 12'h014
`define OFS_EVENT_FIXED 12'h018
`define OFS_ARB_STATUS 12'h01c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PRIO_RESET 16'h0000
`define FLD_3_0 2'h0
`define FLD_7_4 2'h1
`define FLD_11_8 2'h2
`define FLD_15_12 2'h3
`define CODE_RESET 12'h000

// ----------------------------------------
// Levels
// ----------------------------------------
`define LVL_NONE 5'h00
`define LVL_DEBUG 5'h0f
`define LVL_NMI 5'h10
`define LVL_TOP_PROG 5'h0f

// ----------------------------------------
// Source indices, default order highest first
// ----------------------------------------
`define SRC_NMI 5'h00
`define SRC_DEBUG 5'h01
`define SRC_IRQ0 5'h02
`define SRC_IRQ1 5'h03
`define SRC_IRQ2 5'h04
`define SRC_IRQ3 5'h05
`define SRC_IRQ4 5'h06
`define SRC_IRQ5 5'h07
`define SRC_DMA0 5'h08
`define SRC_DMA1 5'h09
`define SRC_DMA2 5'h0a
`define SRC_DMA3 5'h0b
`define SRC_A2_ERR 5'h0c
`define SRC_A2_RX 5'h0d
`define SRC_A2_BRK 5'h0e
`define SRC_A2_TX 5'h0f
`define SRC_CONV 5'h10
`define SRC_TMR0 5'h11
`define SRC_TMR1 5'h12
`define SRC_TMR2_UF 5'h13
`define SRC_TMR2_CAP 5'h14
`define SRC_CLK_ALARM 5'h15
`define SRC_CLK_PER 5'h16
`define SRC_CLK_CARRY 5'h17
`define SRC_A0_ERR 5'h18
`define SRC_A0_RX 5'h19
`define SRC_A0_TX 5'h1a
`define SRC_A0_TEND 5'h1b
`define SRC_WDT 5'h1c
`define SRC_REF_CM 5'h1d
`define SRC_REF_OVF 5'h1e
`define SRC_LAST_LEVEL_CODED 5'h10

// ----------------------------------------
// Event codes
// ----------------------------------------
`define CODE_NMI 12'h1c0
`define CODE_LVL_BASE 12'h200
`define CODE_LVL_STEP 12'h020
`define CODE_DEBUG 12'h5e0
`define CODE_IRQ0 12'h600
`define CODE_IRQ_STEP 12'h020
`define CODE_DMA0 12'h800
`define CODE_A2_ERR 12'h900
`define CODE_CONV 12'h980
`define CODE_TMR0 12'h400
`define CODE_SRC_STEP 12'h020

`endif

// ===== peripheral_irq_priority_encoder.v
// Summary of operation
// - Debug interface source is fixed at level 15, code 0x5e0 in both registers.
// - Other on-chip sources take levels 0..15 from priority_set_a, b or e fields.
// - Acceptance never alters the core's level mask bits.
// - Timer or clock request above mask wakes standby, only with 32-kHz oscillator.
// - Every source has its own code, stored in event registers on acceptance.
// - Reset clears all programmable priorities to zero.
// - Equal levels resolve by fixed default order, NMI first, refresh last.
// - IRQ, DMA, fifo serial, converter: event_code from level, fixed code separate.
// - IRQ0..3 use priority_set_c nibbles, codes 0x600..0x660.
// - IRQ4..5 use priority_set_d low nibbles, codes 0x680 and 0x6a0.
// - DMA channels share priority_set_e 15-12, channel 0 first, codes 0x800..0x860.
// - Fifo serial sources share priority_set_e 7-4, codes 0x900..0x960 in order.
// - Converter done uses priority_set_e 3-0, code 0x980.
// - Timers use priority_set_a 15-12, 11-8, 7-4; codes 0x400..0x460.
// - Clock sources share priority_set_a 3-0, codes 0x480..0x4c0 in order.
// - Serial0 sources share priority_set_b 7-4, codes 0x4e0..0x540 in order.
// - Watchdog interval uses priority_set_b 15-12, code 0x560.
// - Refresh sources share priority_set_b 11-8, codes 0x580 and 0x5a0.
// - Level 0 masks a source; active levels run 1 to 16.
// - NMI is the lone level-16 source, above all others.
`include "irq_priority_regs.vh"

module peripheral_irq_priority_encoder #(
	parameter NSRC = 31,
	parameter AW = 12
) (
	// Clock and reset
	input wire clock,
	input wire reset,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Source requests, bit index is the default order
	input wire [NSRC-1:0] sourceReq,
	// Core side
	input wire [3:0] levelMask,
	input wire coreAccept,
	output reg coreRequest,
	output reg [4:0] coreLevel,
	// Standby wake-up
	input wire standbyMode,
	input wire osc32kInUse,
	output reg wakeRequest
);

	// ----------------------------------------
	// Field selection and code tables
	// ----------------------------------------
	function [3:0] nibble;
		input [15:0] r;
		input [1:0] f;
		begin
			case (f)
				`FLD_3_0: nibble = r[3:0];
				`FLD_7_4: nibble = r[7:4];
				`FLD_11_8: nibble = r[11:8];
				default: nibble = r[15:12];
			endcase
		end
	endfunction

	function [4:0] levelOf;
		input [4:0] s;
		input [15:0] a;
		input [15:0] b;
		input [15:0] c;
		input [15:0] d;
		input [15:0] e;
		begin
			levelOf = `LVL_NONE;
			case (s)
				`SRC_NMI: levelOf = `LVL_NMI;
				`SRC_DEBUG: levelOf = `LVL_DEBUG;
				`SRC_IRQ0: levelOf = {1'b0, nibble(c, `FLD_3_0)};
				`SRC_IRQ1: levelOf = {1'b0, nibble(c, `FLD_7_4)};
				`SRC_IRQ2: levelOf = {1'b0, nibble(c, `FLD_11_8)};
				`SRC_IRQ3: levelOf = {1'b0, nibble(c, `FLD_15_12)};
				`SRC_IRQ4: levelOf = {1'b0, nibble(d, `FLD_3_0)};
				`SRC_IRQ5: levelOf = {1'b0, nibble(d, `FLD_7_4)};
				`SRC_DMA0, `SRC_DMA1, `SRC_DMA2, `SRC_DMA3:
					levelOf = {1'b0, nibble(e, `FLD_15_12)};
				`SRC_A2_ERR, `SRC_A2_RX, `SRC_A2_BRK, `SRC_A2_TX:
					levelOf = {1'b0, nibble(e, `FLD_7_4)};
				`SRC_CONV: levelOf = {1'b0, nibble(e, `FLD_3_0)};
				`SRC_TMR0: levelOf = {1'b0, nibble(a, `FLD_15_12)};
				`SRC_TMR1: levelOf = {1'b0, nibble(a, `FLD_11_8)};
				`SRC_TMR2_UF, `SRC_TMR2_CAP: levelOf = {1'b0, nibble(a, `FLD_7_4)};
				`SRC_CLK_ALARM, `SRC_CLK_PER, `SRC_CLK_CARRY:
					levelOf = {1'b0, nibble(a, `FLD_3_0)};
				`SRC_A0_ERR, `SRC_A0_RX, `SRC_A0_TX, `SRC_A0_TEND:
					levelOf = {1'b0, nibble(b, `FLD_7_4)};
				`SRC_WDT: levelOf = {1'b0, nibble(b, `FLD_15_12)};
				`SRC_REF_CM, `SRC_REF_OVF: levelOf = {1'b0, nibble(b, `FLD_11_8)};
				default: levelOf = `LVL_NONE;
			endcase
		end
	endfunction

	// Source-specific code; on-chip module codes step by 0x20 in index order
	function [11:0] fixedCode;
		input [4:0] s;
		reg [11:0] k;
		begin
			k = {7'h00, s};
			if (s == `SRC_NMI) begin
				fixedCode = `CODE_NMI;
			end else if (s == `SRC_DEBUG) begin
				fixedCode = `CODE_DEBUG;
			end else if (s <= `SRC_IRQ5) begin
				fixedCode = `CODE_IRQ0 + (k - {7'h00, `SRC_IRQ0}) * `CODE_IRQ_STEP;
			end else if (s <= `SRC_DMA3) begin
				fixedCode = `CODE_DMA0 + (k - {7'h00, `SRC_DMA0}) * `CODE_SRC_STEP;
			end else if (s <= `SRC_A2_TX) begin
				fixedCode = `CODE_A2_ERR + (k - {7'h00, `SRC_A2_ERR}) * `CODE_SRC_STEP;
			end else if (s == `SRC_CONV) begin
				fixedCode = `CODE_CONV;
			end else begin
				// Timer, clock, serial0, watchdog and refresh run 0x400..0x5a0 contiguously
				fixedCode = `CODE_TMR0 + (k - {7'h00, `SRC_TMR0}) * `CODE_SRC_STEP;
			end
		end
	endfunction

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg [15:0] prioA_q;
	reg [15:0] prioB_q;
	reg [15:0] prioC_q;
	reg [15:0] prioD_q;
	reg [15:0] prioE_q;
	reg [11:0] eventCode_q;
	reg [11:0] eventFixed_q;
	reg [4:0] winIdx_q;

	wire setupPhase = psel & ~penable;
	wire accessDone = psel & penable & pready;
	reg mapped;
	reg [31:0] readMux;

	always @* begin
		mapped = 1'b1;
		readMux = 32'h00000000;
		case (paddr)
			`OFS_PRIO_A: readMux = {16'h0000, prioA_q};
			`OFS_PRIO_B: readMux = {16'h0000, prioB_q};
			`OFS_PRIO_C: readMux = {16'h0000, prioC_q};
			`OFS_PRIO_D: readMux = {16'h0000, prioD_q};
			`OFS_PRIO_E: readMux = {16'h0000, prioE_q};
			`OFS_EVENT_CODE: readMux = {20'h00000, eventCode_q};
			`OFS_EVENT_FIXED: readMux = {20'h00000, eventFixed_q};
			`OFS_ARB_STATUS: readMux = {20'h00000, winIdx_q, coreLevel, wakeRequest, coreRequest};
			default: mapped = 1'b0;
		endcase
	end

	// Zero-wait slave: ready rises in the first access cycle
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setupPhase;
			pslverr <= setupPhase & ~mapped;
			if (setupPhase & ~pwrite) begin
				prdata <= readMux;
			end
		end
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			prioA_q <= `PRIO_RESET;
			prioB_q <= `PRIO_RESET;
			prioC_q <= `PRIO_RESET;
			prioD_q <= `PRIO_RESET;
			prioE_q <= `PRIO_RESET;
		end else if (accessDone & pwrite) begin
			case (paddr)
				`OFS_PRIO_A: prioA_q <= pwdata[15:0];
				`OFS_PRIO_B: prioB_q <= pwdata[15:0];
				`OFS_PRIO_C: prioC_q <= pwdata[15:0];
				`OFS_PRIO_D: prioD_q <= pwdata[15:0];
				`OFS_PRIO_E: prioE_q <= pwdata[15:0];
				default: prioA_q <= prioA_q;
			endcase
		end
	end

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	reg [4:0] bestLvl;
	reg [4:0] bestIdx;
	reg [4:0] curLvl;
	reg wakeHit;
	integer i;

	// Scan downward with >= so the lowest index wins a tie
	always @* begin
		bestLvl = `LVL_NONE;
		bestIdx = `SRC_NMI;
		curLvl = `LVL_NONE;
		wakeHit = 1'b0;
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			curLvl = levelOf(i[4:0], prioA_q, prioB_q, prioC_q, prioD_q, prioE_q);
			if (sourceReq[i] && curLvl != `LVL_NONE && curLvl >= bestLvl) begin
				bestLvl = curLvl;
				bestIdx = i[4:0];
			end
			if (sourceReq[i] && i[4:0] >= `SRC_TMR0 && i[4:0] <= `SRC_CLK_CARRY &&
					curLvl > {1'b0, levelMask}) begin
				wakeHit = 1'b1;
			end
		end
	end

	wire present = (bestLvl != `LVL_NONE) &&
		((bestLvl > {1'b0, levelMask}) || (bestIdx == `SRC_NMI));

	// Level-derived code for levels 1..15; NMI keeps its own
	wire [11:0] levelCode = `CODE_LVL_BASE +
		{7'h00, `LVL_TOP_PROG - coreLevel} * `CODE_LVL_STEP;

	// ----------------------------------------
	// Core request and event registers
	// ----------------------------------------
	// The level mask is an input only: nothing here writes it back on acceptance.
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			coreRequest <= 1'b0;
			coreLevel <= `LVL_NONE;
			winIdx_q <= `SRC_NMI;
			wakeRequest <= 1'b0;
			eventCode_q <= `CODE_RESET;
			eventFixed_q <= `CODE_RESET;
		end else begin
			coreRequest <= present;
			coreLevel <= present ? bestLvl : `LVL_NONE;
			winIdx_q <= bestIdx;
			wakeRequest <= standbyMode & osc32kInUse & wakeHit;
			if (coreAccept & coreRequest) begin
				eventFixed_q <= fixedCode(winIdx_q);
				if (winIdx_q >= `SRC_IRQ0 && winIdx_q <= `SRC_LAST_LEVEL_CODED) begin
					eventCode_q <= levelCode;
				end else begin
					eventCode_q <= fixedCode(winIdx_q);
				end
			end
		end
	end

endmodule

// ===== irq_prio_checker_sva.sv
module irq_prio_checker #(
	parameter NSRC = 31,
	parameter AW = 12
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sources and core
	input wire logic [NSRC-1:0] sourceReq,
	input wire logic [3:0] levelMask,
	input wire logic coreAccept,
	input wire logic coreRequest,
	input wire logic [4:0] coreLevel,
	input wire logic standbyMode,
	input wire logic osc32kInUse,
	input wire logic wakeRequest
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	a_nmi_top: assert property (sourceReq[0] |=> coreRequest && coreLevel == 5'h10) else $error("nmi level");
	a_debug_fixed: assert property (sourceReq[1:0] == 2'h2 && levelMask != 4'hf |=> coreLevel == 5'h0f) else $error("debug");
	a_idle_quiet: assert property (sourceReq == '0 |=> !coreRequest && coreLevel == 5'h00) else $error("idle");
	a_mask_gate: assert property (coreRequest |-> coreLevel == 5'h10 || coreLevel > {1'b0, $past(levelMask)})
		else $error("mask");
	a_level_live: assert property (coreRequest |-> coreLevel != 5'h00) else $error("zero level");
	a_mask_full: assert property (levelMask == 4'hf && !sourceReq[0] |=> !coreRequest) else $error("full mask");
	a_wake_osc: assert property (!(standbyMode && osc32kInUse) |=> !wakeRequest) else $error("wake gate");
	a_wake_source: assert property (sourceReq[23:17] == 7'h00 |=> !wakeRequest) else $error("wake source");
	a_err_ready: assert property (pslverr |-> pready && psel && penable) else $error("slverr");
	a_ready_setup: assert property (psel && !penable |=> pready [*1] ##1 !pready) else $error("ready");
endmodule

// ===== cpu_core_model.sv
module cpu_core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Core side
	input wire logic coreRequest,
	input wire logic [3:0] delay,
	output logic coreAccept
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] count_q;
	logic taken_q;
	// One accept per held request, after a chosen wait
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			count_q <= 4'h0;
			taken_q <= 1'b0;
			coreAccept <= 1'b0;
		end else begin
			coreAccept <= 1'b0;
			if (!coreRequest) begin
				count_q <= 4'h0;
				taken_q <= 1'b0;
			end else if (!taken_q && count_q >= delay) begin
				coreAccept <= 1'b1;
				taken_q <= 1'b1;
			end else if (!taken_q) begin
				count_q <= count_q + 4'h1;
			end
		end
	end
endmodule

// ===== peripheral_irq_priority_encoder_tb.sv
module peripheral_irq_priority_encoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
	logic clock, reset, psel, penable, pwrite, pready, pslverr, coreAccept, coreRequest, standbyMode, osc32kInUse, wakeRequest;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [30:0] sourceReq;
	logic [3:0] levelMask, delay;
	logic [4:0] coreLevel;
	logic [15:0] prio [5];
	logic [32:0] expq [$];
	int fail_count, compares, cycles, lvl, i;
	// Register index times four plus nibble, per source
	localparam byte FMAP [31] = '{0, 0, 8, 9, 10, 11, 12, 13, 19, 19, 19, 19, 17, 17, 17, 17, 16, 3, 2, 1, 1, 0, 0, 0,
		5, 5, 5, 5, 7, 6, 6};
	peripheral_irq_priority_encoder u_peripheral_irq_priority_encoder (.clock, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sourceReq, .levelMask, .coreAccept, .coreRequest, .coreLevel, .standbyMode,
		.osc32kInUse, .wakeRequest);
	cpu_core_model u_cpu_core_model (.clock, .reset, .coreRequest, .delay, .coreAccept);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles > 6000) begin
			fail_count++;
			end_sim();
		end
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
			`CHK({pslverr, prdata}, expq.pop_front())
	end
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic setlvl(input int s, input logic [3:0] l);
		int r;
		r = FMAP[s] / 4;
		prio[r][4 * (FMAP[s] % 4) +: 4] = l;
		xfer(1'b1, 12'(4 * r), {16'h0000, prio[r]});
	endtask
	function automatic logic [11:0] fixcode(input int s);
		if (s == 0) return 12'h1c0;
		if (s == 1) return 12'h5e0;
		if (s < 8) return 12'h600 + 12'(32 * (s - 2));
		if (s < 12) return 12'h800 + 12'(32 * (s - 8));
		if (s < 17) return 12'h900 + 12'(32 * (s - 12));
		return 12'h400 + 12'(32 * (s - 17));
	endfunction
	initial begin
		{reset, psel, penable, pwrite, standbyMode, osc32kInUse} = 6'h20;
		{paddr, pwdata, sourceReq, levelMask, delay} = '0;
		i = $urandom(10);
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		for (i = 0; i < 5; i++) begin
			lvl = $urandom;
			prio[i] = lvl[15:0];
			xfer(1'b1, 12'(4 * i), 32'(lvl));
			rd(12'(4 * i), {17'h0, prio[i]});
		end
		rd(12'h020, {1'b1, 32'h0});
		reset <= 1'b1;
		@(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		for (i = 0; i < 5; i++) begin
			prio[i] = 16'h0000;
			rd(12'(4 * i), 33'h0);
		end
		// --------------------------------
		// Every source; sources 2 to 29 paired with the next one at equal level
		// --------------------------------
		for (i = 0; i < 31; i++) begin
			lvl = $urandom_range(15, 1);
			if (i > 1) setlvl(i, 4'(lvl));
			if (i > 1 && i < 30) setlvl(i + 1, 4'(lvl));
			delay <= 4'($urandom_range(3, 0));
			sourceReq <= (31'h1 << i) | (i < 30 ? 31'h1 << (i + 1) : 31'h0);
			do @(posedge clock); while (coreAccept !== 1'b1);
			`CHK(coreLevel, i == 0 ? 5'h10 : i == 1 ? 5'h0f : 5'(lvl))
			sourceReq <= '0;
			rd(12'h014, {21'h0, (i > 1 && i < 17) ? 12'h200 + 12'(32 * (15 - lvl)) : fixcode(i)});
			rd(12'h018, {21'h0, fixcode(i)});
		end
		// --------------------------------
		// Masking and standby wake
		// --------------------------------
		setlvl(17, 4'h0);
		sourceReq <= 31'h1 << 17;
		repeat (3) @(posedge clock);
		`CHK(coreRequest, 1'b0)
		setlvl(17, 4'h6);
		levelMask <= 4'h6;
		{standbyMode, osc32kInUse} <= 2'h3;
		repeat (3) @(posedge clock);
		`CHK({coreRequest, wakeRequest}, 2'h0)
		levelMask <= 4'h5;
		repeat (3) @(posedge clock);
		`CHK({coreLevel, wakeRequest}, 6'h0d)
		osc32kInUse <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK(wakeRequest, 1'b0)
		sourceReq <= '0;
		repeat (3) @(posedge clock);
		end_sim();
	end
endmodule
bind peripheral_irq_priority_encoder irq_prio_checker #(.NSRC(NSRC), .AW(AW)) u_irq_prio_checker (.clock, .reset, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sourceReq, .levelMask, .coreAccept, .coreRequest,
	.coreLevel, .standbyMode, .osc32kInUse, .wakeRequest);
